// ==== rtl/aro_top.sv ====
// What this block does
// - resolution select field chooses 12, 10, 8 or 6 bit conversions.
// - approximation phase lasts 12.5, 10.5, 8.5 or 6.5 cycles by resolution.
// - sampling at least 1.5 cycles; totals 14, 12, 10 or 8 cycles with smp_x at zero, one more per smp_x step.
// - oversampling sums raw results into one word, at most 16 bits.
// - three-bit ratio field selects 2x up to 256x conversions per word.
// - four-bit shift field selects right shift of zero to eight bits.
// - accumulator holds 20-bit sums; shift applied before width reduction.
// - shifted result rounded to nearest, then low 16 bits kept.
// - excess high bits dropped silently, no saturation or overflow flag.
// - each oversampled conversion keeps standard sampling and conversion timing.
// - one output word after every N conversions, latency N conversion times.
// - oversampling works with both conv_start and continuous conversion modes.
`include "aro_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module aro_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic conv_start,
  input wire logic [11:0] raw_data,
  output aro_pkg::aro_core_t core_ctl,
  output aro_pkg::aro_out_t result
);

  aro_pkg::aro_st_t s;
  aro_pkg::aro_st_t n;

  // total conversion time in whole cycles from half-cycle figures
  function automatic logic [4:0] t_adc(input aro_pkg::aro_res_t r, input logic [2:0] x);
    logic [5:0] conv_h;
    logic [5:0] tot_h;
    unique case (r)
      aro_pkg::ARO_RES12: conv_h = `ARO_TCONV12_H;
      aro_pkg::ARO_RES10: conv_h = `ARO_TCONV10_H;
      aro_pkg::ARO_RES8: conv_h = `ARO_TCONV8_H;
      aro_pkg::ARO_RES6: conv_h = `ARO_TCONV6_H;
    endcase
    tot_h = `ARO_TSMPL_MIN_H + {2'h0, x, 1'b0} + conv_h;
    return tot_h[5:1];
  endfunction

  // sampling cycles: the half-cycle edge is rounded up to the next clock edge
  function automatic logic [4:0] t_smp(input logic [2:0] x);
    logic [5:0] h;
    h = `ARO_TSMPL_MIN_H + {2'h0, x, 1'b0} + 6'h01;
    return h[5:1];
  endfunction

  function automatic logic [11:0] raw_mask(input aro_pkg::aro_res_t r);
    return `ARO_RAW_FULL >> {r, 1'b0};
  endfunction

  function automatic logic [7:0] last_cnt(input logic [2:0] code);
    logic [8:0] ratio;
    ratio = 9'h002 << code;
    return 8'(ratio - 9'h001);
  endfunction

  function automatic logic [3:0] eff_shift(input logic [3:0] sh);
    return (sh > `ARO_SHIFT_MAX) ? `ARO_SHIFT_MAX : sh;
  endfunction

  function automatic logic [15:0] round_shift(input logic [19:0] sum, input logic [3:0] sh);
    logic [19:0] t;
    logic rb;
    rb = (sh == 4'h0) ? 1'b0 : sum[sh - 4'h1];
    t = (sum >> sh) + {19'h0, rb};
    return t[15:0];
  endfunction

  logic req;
  logic take;
  logic last;
  logic fire;
  logic [11:0] raw_m;
  logic [19:0] sum_w;
  logic [3:0] sh_w;

  assign req = avs_read | avs_write;
  assign take = req & ~s.wait_r;
  assign last = (s.phase == aro_pkg::ARO_CONVERT) && (s.cyc == t_adc(s.cfg.res, s.cfg.smp_x) - 5'h01);
  assign raw_m = raw_data & raw_mask(s.cfg.res);
  assign sum_w = s.acc + {8'h00, raw_m};
  assign sh_w = eff_shift(s.cfg.shift);
  assign fire = last & s.cfg.ovs_en & (s.cnt == last_cnt(s.cfg.ratio));

  always_comb begin
    logic [15:0] wd;
    logic restart;
    wd = avs_writedata[15:0];
    restart = 1'b0;
    n = s;
    n.out.valid = 1'b0;
    n.wait_r = 1'b1;

    // bus: one wait cycle, then the request is taken
    if (req && s.wait_r) begin
      n.wait_r = 1'b0;
      unique case (avs_address)
        // bit 7 is unused so the shift field sits on its own lane
        `ARO_REG_CTRL: n.rdata = {16'h0000, s.cfg.cont, s.cfg.smp_x, s.cfg.shift, 1'b0,
                                  s.cfg.ratio, s.cfg.ovs_en, s.cfg.res, s.cfg.on};
        `ARO_REG_STAT: n.rdata = {16'h0000, s.cnt, 4'h0, s.phase, s.ready,
                                  s.phase != aro_pkg::ARO_IDLE};
        `ARO_REG_DATA: n.rdata = {16'h0000, s.out.data};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (take && avs_write && avs_address == `ARO_REG_CTRL) begin
      if (avs_byteenable[0]) begin
        n.cfg.on = wd[`ARO_CTL_ON];
      end
      // fields are frozen while running so a half-built word never escapes
      if (!s.cfg.on) begin
        if (avs_byteenable[0]) begin
          n.cfg.res = aro_pkg::aro_res_t'(wd[`ARO_CTL_RES_LSB +: 2]);
          n.cfg.ovs_en = wd[`ARO_CTL_OVS_EN];
          n.cfg.ratio = wd[`ARO_CTL_RATIO_LSB +: 3];
        end
        if (avs_byteenable[1]) begin
          n.cfg.shift = wd[`ARO_CTL_SHIFT_LSB +: 4];
          n.cfg.smp_x = wd[`ARO_CTL_SMPX_LSB +: 3];
          n.cfg.cont = wd[`ARO_CTL_CONT];
        end
      end
    end
    if (take && avs_read && avs_address == `ARO_REG_DATA) begin
      n.ready = 1'b0;
    end

    // conversion sequencing, same for every mode that issues starts
    unique case (s.phase)
      aro_pkg::ARO_IDLE: begin
        if (s.cfg.on && (s.pend || s.cfg.cont)) begin
          restart = 1'b1;
        end
      end
      aro_pkg::ARO_SAMPLE: begin
        n.cyc = s.cyc + 5'h01;
        if (s.cyc == t_smp(s.cfg.smp_x) - 5'h01) begin
          n.phase = aro_pkg::ARO_CONVERT;
        end
      end
      aro_pkg::ARO_CONVERT: begin
        n.cyc = s.cyc + 5'h01;
        if (last) begin
          if (s.cfg.ovs_en) begin
            if (fire) begin
              n.out.data = round_shift(sum_w, sh_w);
              n.out.valid = 1'b1;
              n.ready = 1'b1;
              n.acc = 20'h00000;
              n.cnt = 8'h00;
            end else begin
              n.acc = sum_w;
              n.cnt = s.cnt + 8'h01;
            end
          end else begin
            n.out.data = {4'h0, raw_m};
            n.out.valid = 1'b1;
            n.ready = 1'b1;
          end
          n.phase = aro_pkg::ARO_IDLE;
          // back to back keeps every conversion the same length
          if (s.cfg.on && (s.pend || s.cfg.cont)) begin
            restart = 1'b1;
          end
        end
      end
      default: n.phase = aro_pkg::ARO_IDLE;
    endcase
    if (restart) begin
      n.phase = aro_pkg::ARO_SAMPLE;
      n.cyc = 5'h00;
      n.pend = 1'b0;
    end
    // a start in the consuming cycle stays pending
    if (conv_start) begin
      n.pend = 1'b1;
    end
    // switching off aborts and drops a partial sum
    if (!s.cfg.on) begin
      n.phase = aro_pkg::ARO_IDLE;
      n.cyc = 5'h00;
      n.acc = 20'h00000;
      n.cnt = 8'h00;
      n.pend = 1'b0;
    end
    n.core.sample = (n.phase == aro_pkg::ARO_SAMPLE);
    n.core.convert = (n.phase == aro_pkg::ARO_CONVERT);
    n.core.res = n.cfg.res;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.wait_r <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wait_r;
  assign core_ctl = s.core;
  assign result = s.out;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  // checking helpers
  logic [4:0] smp_len;
  logic [19:0] half_lsb;
  logic [19:0] chk_sum;
  assign smp_len = t_smp(s.cfg.smp_x);
  assign half_lsb = (sh_w == 4'h0) ? 20'h00000 : (20'h00001 << (sh_w - 4'h1));
  assign chk_sum = sum_w + half_lsb;

  res_to_core_a: assert property (core_ctl.res == s.cfg.res)
    else $error("core resolution differs from control");

  res_frozen_a: assert property (s.cfg.on && $past(s.cfg.on) |-> $stable(s.cfg))
    else $error("configuration changed while converter on");

  conv_len_a: assert property (ce && s.phase == aro_pkg::ARO_SAMPLE && s.cyc == smp_len - 5'h01
      |=> s.phase == aro_pkg::ARO_CONVERT || !s.cfg.on)
    else $error("sampling phase did not hand over to conversion");

  total_len_a: assert property (ce && last |-> s.cyc + 5'h01 ==
      t_adc(s.cfg.res, s.cfg.smp_x))
    else $error("conversion length wrong");

  smp_min_a: assert property (s.phase == aro_pkg::ARO_CONVERT |-> s.cyc >= 5'd2)
    else $error("sampling shorter than two cycles");

  acc_range_a: assert property (s.acc <= `ARO_ACC_MAX)
    else $error("accumulator beyond 20-bit range");

  round_out_a: assert property (ce && fire |=> result.valid &&
      result.data == 16'($past(chk_sum) >> $past(sh_w)))
    else $error("rounded result wrong");

  ratio_cnt_a: assert property (ce && last && s.cfg.on && s.cfg.ovs_en && !fire
      |=> s.cnt == $past(s.cnt) + 8'h01 && !result.valid)
    else $error("ratio count did not advance");

  word_gate_a: assert property (result.valid && s.cfg.ovs_en |-> $past(s.cnt) ==
      last_cnt(s.cfg.ratio))
    else $error("word issued before ratio reached");

  wait_once_a: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // phase and core lines, one conversion at a time
  off_clear_a: assert property (ce && !s.cfg.on |=> s.phase == aro_pkg::ARO_IDLE &&
      s.acc == 20'h00000 && s.cnt == 8'h00)
    else $error("switching off left state behind");

  core_excl_a: assert property (!(core_ctl.sample && core_ctl.convert))
    else $error("core told to sample and convert at once");

  core_smp_a: assert property (core_ctl.sample == (s.phase == aro_pkg::ARO_SAMPLE))
    else $error("sample line differs from phase");

  core_cnv_a: assert property (core_ctl.convert == (s.phase == aro_pkg::ARO_CONVERT))
    else $error("convert line differs from phase");

  idle_core_a: assert property (s.phase == aro_pkg::ARO_IDLE |-> !core_ctl.sample)
    else $error("core sampling while idle");

  smp_len_a: assert property (ce && s.phase == aro_pkg::ARO_SAMPLE |-> s.cyc < smp_len)
    else $error("sampling phase too long");

  conv_cap_a: assert property (s.phase == aro_pkg::ARO_CONVERT |->
      s.cyc < t_adc(s.cfg.res, s.cfg.smp_x))
    else $error("conversion phase too long");

  start_idle_a: assert property (ce && s.phase == aro_pkg::ARO_IDLE && s.cfg.on &&
      (s.pend || s.cfg.cont) |=> s.phase == aro_pkg::ARO_SAMPLE && s.cyc == 5'h00)
    else $error("start not taken while idle");

  pend_keep_a: assert property (ce && conv_start && s.cfg.on |=> s.pend)
    else $error("start request lost");

  // datapath, plain and oversampled
  raw_pass_a: assert property (ce && last && !s.cfg.ovs_en |=> result.valid &&
      result.data == {4'h0, $past(raw_m)})
    else $error("plain conversion word wrong");

  raw_width_a: assert property (result.valid && !s.cfg.ovs_en |-> result.data[15:12] == 4'h0 &&
      (result.data[11:0] & ~raw_mask(s.cfg.res)) == 12'h000)
    else $error("plain word wider than resolution");

  valid_pulse_a: assert property (ce && result.valid |=> !result.valid)
    else $error("valid longer than one cycle");

  ready_with_a: assert property (result.valid |-> s.ready)
    else $error("ready not set with new word");

  data_hold_a: assert property (!result.valid && $past(ce) |-> $stable(result.data))
    else $error("data changed without valid");

  shift_cap_a: assert property (sh_w <= `ARO_SHIFT_MAX)
    else $error("shift beyond eight bits");

  cnt_limit_a: assert property (s.cnt <= last_cnt(s.cfg.ratio))
    else $error("conversion count beyond ratio");

  acc_clear_a: assert property (ce && fire |=> s.acc == 20'h00000 && s.cnt == 8'h00)
    else $error("accumulator not cleared after word");

  acc_add_a: assert property (ce && last && s.cfg.on && s.cfg.ovs_en && !fire
      |=> s.acc == $past(sum_w))
    else $error("accumulator did not add raw result");

  round_zero_a: assert property (ce && fire && sh_w == 4'h0
      |=> result.data == $past(sum_w[15:0]))
    else $error("zero shift word was rounded");

  ovs_quiet_a: assert property (!s.cfg.ovs_en && s.cfg.on |->
      s.cnt == 8'h00 && s.acc == 20'h00000)
    else $error("accumulator moved without oversampling");

endmodule

`default_nettype wire

// ==== rtl/aro_defines.svh ====
`ifndef ARO_DEFINES_SVH
`define ARO_DEFINES_SVH

// register byte offsets
`define ARO_REG_CTRL 4'h0
`define ARO_REG_STAT 4'h4
`define ARO_REG_DATA 4'h8

// control word field positions
`define ARO_CTL_ON 0
`define ARO_CTL_RES_LSB 1
`define ARO_CTL_OVS_EN 3
`define ARO_CTL_RATIO_LSB 4
`define ARO_CTL_SHIFT_LSB 8
`define ARO_CTL_SMPX_LSB 12
`define ARO_CTL_CONT 15

// status word field positions
`define ARO_STA_BUSY 0
`define ARO_STA_READY 1
`define ARO_STA_PHASE_LSB 2
`define ARO_STA_CNT_LSB 8

// reset values
`define ARO_CTRL_RST 16'h0000
`define ARO_DATA_RST 16'h0000

// timing in half converter clock cycles
`define ARO_TSMPL_MIN_H 6'h03
`define ARO_TCONV12_H 6'h19
`define ARO_TCONV10_H 6'h15
`define ARO_TCONV8_H 6'h11
`define ARO_TCONV6_H 6'h0d

// datapath limits
`define ARO_RAW_FULL 12'hfff
`define ARO_ACC_MAX 20'hfff00
`define ARO_SHIFT_MAX 4'h8

`endif

// ==== rtl/aro_pkg.sv ====
package aro_pkg;

  typedef enum logic [1:0] {ARO_RES12, ARO_RES10, ARO_RES8, ARO_RES6} aro_res_t;

  typedef enum logic [1:0] {ARO_IDLE, ARO_SAMPLE, ARO_CONVERT} aro_phase_t;

  typedef struct packed {
    logic cont;
    logic [2:0] smp_x;
    logic [3:0] shift;
    logic [2:0] ratio;
    logic ovs_en;
    aro_res_t res;
    logic on;
  } aro_cfg_t;

  typedef struct packed {
    logic sample;
    logic convert;
    aro_res_t res;
  } aro_core_t;

  typedef struct packed {
    logic [15:0] data;
    logic valid;
  } aro_out_t;

  typedef struct packed {
    aro_cfg_t cfg;
    aro_phase_t phase;
    logic [4:0] cyc;
    logic [19:0] acc;
    logic [7:0] cnt;
    logic pend;
    aro_core_t core;
    aro_out_t out;
    logic ready;
    logic wait_r;
    logic [31:0] rdata;
  } aro_st_t;

endpackage

// ==== sim/aro_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module aro_core_model (
  input wire logic clk,
  input wire aro_pkg::aro_core_t core_ctl,
  input wire logic [11:0] level,
  output logic [11:0] raw_data
);
  logic [11:0] last_ff = 12'h000;
  // lines toggle outside convert so a stale value never passes
  always @(posedge clk) begin
    last_ff <= core_ctl.convert ? level : ~last_ff;
  end
  assign raw_data = core_ctl.convert ? level : last_ff;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`include "aro_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_start = 1'b0;
  logic [11:0] raw_data;
  logic [11:0] level = 12'habc;
  aro_pkg::aro_core_t core_ctl;
  aro_pkg::aro_out_t result;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n, ns, nc;
  logic [31:0] rd;
  int rt[5] = '{0, 0, 7, 7, 1};
  int sf[5] = '{0, 2, 0, 9, 3};
  logic [11:0] rw[5] = '{12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h007};
  aro_top dut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_start(conv_start),
    .raw_data(raw_data), .core_ctl(core_ctl), .result(result));
  aro_core_model core (.clk(clk), .core_ctl(core_ctl), .level(level),
    .raw_data(raw_data));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic start();
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
  endtask
  task automatic wait_word();
    n = 0;
    ns = 0;
    nc = 0;
    do begin
      @(posedge clk);
      n++;
      ns += core_ctl.sample;
      nc += core_ctl.convert;
    end while (result.valid !== 1'b1 && n < 8000);
  endtask
  function automatic logic [31:0] cfg(input int r, input logic o, input int q,
      input int s, input logic c);
    cfg = 32'h0;
    cfg[`ARO_CTL_RES_LSB +: 2] = r[1:0];
    cfg[`ARO_CTL_OVS_EN] = o;
    cfg[`ARO_CTL_RATIO_LSB +: 3] = q[2:0];
    cfg[`ARO_CTL_SHIFT_LSB +: 4] = s[3:0];
    cfg[`ARO_CTL_CONT] = c;
  endfunction
  function automatic logic [15:0] ovs_exp(input int q, input int s,
      input logic [11:0] raw);
    logic [19:0] sum;
    int k;
    sum = (20'h2 << q) * raw;
    k = s > 8 ? 8 : s;
    ovs_exp = (sum >> k) + (k > 0 ? sum[k-1] : 1'b0);
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(`ARO_REG_CTRL, 32'h0);
    rchk(`ARO_REG_STAT, 32'h0);
    rchk(`ARO_REG_DATA, 32'h0);
    rchk(4'hc, 32'h0);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, `ARO_REG_CTRL, cfg(r, 0, 0, 0, 0));
      bus(1'b1, `ARO_REG_CTRL, cfg(r, 0, 0, 0, 0) | 32'h1);
      bus(1'b1, `ARO_REG_CTRL, cfg(3 - r, 1, 5, 4, 0) | 32'h1);
      rchk(`ARO_REG_CTRL, cfg(r, 0, 0, 0, 0) | 32'h1);
      check(core_ctl.res, r);
      start();
      wait_word();
      check(n, 16 - 2 * r);
      check(ns, 2);
      check(nc, 12 - 2 * r);
      check(result.data, {4'h0, level & (12'hfff >> (2 * r))});
      bus(1'b0, `ARO_REG_STAT, 32'h0);
      check(rd & 32'h3, 32'h2);
      rchk(`ARO_REG_DATA, {20'h0, level & (12'hfff >> (2 * r))});
      bus(1'b0, `ARO_REG_STAT, 32'h0);
      check(rd & 32'h3, 32'h0);
      bus(1'b1, `ARO_REG_CTRL, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      level <= rw[i];
      bus(1'b1, `ARO_REG_CTRL, cfg(0, 1, rt[i], sf[i], 1));
      bus(1'b1, `ARO_REG_CTRL, cfg(0, 1, rt[i], sf[i], 1) | 32'h1);
      wait_word();
      check(result.data, ovs_exp(rt[i], sf[i], rw[i]));
      wait_word();
      check(n, 28 << rt[i]);
      check(ns, 4 << rt[i]);
      check(result.data, ovs_exp(rt[i], sf[i], rw[i]));
      bus(1'b1, `ARO_REG_CTRL, 32'h0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
